// >>> rtl/ccss_pkg.sv
package ccss_pkg;
    // register byte addresses on the axi4-lite slave
    localparam logic [7:0] PROC_CLOCK_CTRL_ADDR = 8'h00;
    localparam logic [7:0] MAIN_CLOCK_MODE_ADDR = 8'h04;
    localparam logic [7:0] MAIN_OSC_CTRL_ADDR = 8'h08;
    localparam logic [7:0] INT_OSC_MODE_ADDR = 8'h0C;
    localparam logic [7:0] OSC_MODE_SELECT_ADDR = 8'h10;
    localparam logic [7:0] CPU_STATE_ADDR = 8'h14;
    localparam logic [7:0] STANDBY_CMD_ADDR = 8'h18;
    // field positions
    localparam int CPU_SUB_SEL_BIT = 4;
    localparam int CPU_ON_SUB_STATUS_BIT = 5;
    localparam int HS_SOURCE_SEL_BIT = 2;
    localparam int MAIN_ON_HS_STATUS_BIT = 1;
    localparam int MAIN_CLK_SEL_BIT = 0;
    localparam int MAIN_OSC_HALT_BIT = 7;
    localparam int INT_HS_OSC_READY_BIT = 7;
    localparam int INT_HS_OSC_HALT_BIT = 0;
    localparam int EXT_CLK_INPUT_SEL_BIT = 7;
    localparam int MAIN_OSC_PIN_ENABLE_BIT = 6;
    localparam int OSC_GAIN_HIGH_BIT = 5;
    localparam int SUB_OSC_PIN_ENABLE_BIT = 4;
    localparam int HALT_CMD_BIT = 0;
    localparam int STOP_CMD_BIT = 1;
    localparam int WAKE_CMD_BIT = 2;
    // reset values
    localparam logic MAIN_OSC_HALT_RST = 1'b1;
    localparam logic INT_HS_OSC_HALT_RST = 1'b0;
    // timing: reset processing after power-on clear, 11 to 47 us
    localparam int POR_PROC_MIN_NS = 11000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_PROC_CYCLES = (POR_PROC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CNT_W = 11;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // cpu clock / standby states
    typedef enum logic [3:0] {
        CCSS_RESET, CCSS_POR_WAIT, CCSS_INT_RUN, CCSS_HS_RUN, CCSS_SUB_RUN,
        CCSS_INT_HALT, CCSS_HS_HALT, CCSS_SUB_HALT, CCSS_INT_STOP, CCSS_HS_STOP
    } ccss_state_t;
    // cpu clock source codes
    typedef enum logic [1:0] {
        CCSS_SRC_INT, CCSS_SRC_HS, CCSS_SRC_SUB
    } ccss_src_t;
endpackage

// >>> rtl/ccss_glitch_mux.sv
`timescale 1ns/1ps
`default_nettype none
// two-input glitch-free clock switch sampled in the ref domain
module ccss_glitch_mux
    import ccss_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sel,
    input wire logic clk_a,
    input wire logic clk_b,
    output logic clk_out,
    output logic on_b
);
    typedef struct packed {
        logic en_a;
        logic en_b;
    } ccss_gm_t;
    ccss_gm_t q;
    ccss_gm_t next_q;

    // break-before-make: drop old enable before raising new one
    always_comb begin
        next_q = q;
        if (sel) begin
            if (q.en_a && !clk_a) next_q.en_a = 1'b0;
            if (!q.en_a && !next_q.en_a && !clk_b) next_q.en_b = 1'b1;
        end else begin
            if (q.en_b && !clk_b) next_q.en_b = 1'b0;
            if (!q.en_b && !next_q.en_b && !clk_a) next_q.en_a = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{en_a: 1'b1, en_b: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    // enables only change while the gated clock is low
    assign clk_out = (clk_a & q.en_a) | (clk_b & q.en_b);
    assign on_b = q.en_b;
endmodule // ccss_glitch_mux
`default_nettype wire

// >>> rtl/ccss_sequencer.sv
// Functional notes
// (RULE1) reset release runs cpu on internal oscillator
// (RULE2) high por threshold holds reset, then delays
// (RULE3) software: gain, ext sel, enable, halt, settle, select
// (RULE4) software picks gain and external input by frequency
// (RULE5) gain and source select change once per reset
// (RULE6) software may skip already set flags
// (RULE7) software enables sub osc, waits, selects sub
// (RULE8) software: unhalt int osc, check ready, clear main
// (RULE9) software: unhalt, ready, clear main, clear sub
// (RULE10) sub to high-speed: same sequence, clear sub last
// (RULE11) halt instruction enters halt of current source
// (RULE12) software stops peripherals; no stop from sub
// (RULE13) cpu sub select at bit 4
// (RULE14) source select bit 2, main select bit 0
// (RULE15) main osc halt at bit 7
// (RULE16) int osc ready bit 7, halt bit 0
// (RULE17) external input select at bit 7
// (RULE18) sub osc pin enable at bit 4
// (RULE19) source/main select route main and peripheral
// (RULE20) two status flags report active cpu clock
// (RULE21) keep old source, switch without runt pulses
`timescale 1ns/1ps
`default_nettype none
module ccss_sequencer
    import ccss_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic POR_THRESHOLD_SEL,
    input wire logic SUPPLY_ABOVE_THRESHOLD,
    input wire logic INT_OSC_CLK,
    input wire logic HS_SYS_CLK,
    input wire logic SUB_CLK,
    input wire logic INT_OSC_STABLE,
    input wire logic HALT_EXEC,
    input wire logic STOP_EXEC,
    input wire logic WAKE_EVENT,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic CPU_CLK,
    output logic MAIN_CLK,
    output logic PERIPH_CLK,
    output logic CPU_RESET_N,
    output logic CPU_HALTED,
    output logic CPU_STOPPED,
    output logic MAIN_OSC_RUN,
    output logic INT_OSC_RUN,
    output logic SUB_OSC_RUN,
    output logic EXT_CLK_INPUT_SEL,
    output logic OSC_GAIN_HIGH
);
    typedef struct packed {
        ccss_state_t state;
        logic [POR_CNT_W-1:0] por_cnt;
        logic cpu_sub_sel;
        logic hs_source_sel;
        logic main_clk_sel;
        logic main_osc_halt;
        logic int_hs_osc_halt;
        logic ext_clk_input_sel;
        logic main_osc_pin_enable;
        logic osc_gain_high;
        logic sub_osc_pin_enable;
        logic gain_locked;
        logic src_locked;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ccss_seq_t;
    ccss_seq_t q;
    ccss_seq_t next_q;
    logic main_on_hs_status;
    logic cpu_on_sub_status;
    logic main_clk_raw;
    logic cpu_clk_raw;
    logic running;
    logic do_write;
    logic [7:0] wd;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;

    // main clock switch: internal vs high-speed system clock
    ccss_glitch_mux u_main_mux (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .sel(q.hs_source_sel & q.main_clk_sel),
        .clk_a(INT_OSC_CLK),
        .clk_b(HS_SYS_CLK),
        .clk_out(main_clk_raw),
        .on_b(main_on_hs_status)
    ); // RULE19 RULE21

    // cpu clock switch: main vs subsystem clock
    ccss_glitch_mux u_cpu_mux (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .sel(q.cpu_sub_sel),
        .clk_a(main_clk_raw),
        .clk_b(SUB_CLK),
        .clk_out(cpu_clk_raw),
        .on_b(cpu_on_sub_status)
    ); // RULE21

    // read mux and decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (ARADDR)
            PROC_CLOCK_CTRL_ADDR: begin
                rd_word[CPU_SUB_SEL_BIT] = q.cpu_sub_sel; // RULE13
                rd_word[CPU_ON_SUB_STATUS_BIT] = cpu_on_sub_status; // RULE20
            end
            MAIN_CLOCK_MODE_ADDR: begin
                rd_word[HS_SOURCE_SEL_BIT] = q.hs_source_sel; // RULE14
                rd_word[MAIN_ON_HS_STATUS_BIT] = main_on_hs_status; // RULE20
                rd_word[MAIN_CLK_SEL_BIT] = q.main_clk_sel;
            end
            MAIN_OSC_CTRL_ADDR: rd_word[MAIN_OSC_HALT_BIT] = q.main_osc_halt; // RULE15
            INT_OSC_MODE_ADDR: begin
                rd_word[INT_HS_OSC_READY_BIT] = INT_OSC_STABLE & ~q.int_hs_osc_halt; // RULE16
                rd_word[INT_HS_OSC_HALT_BIT] = q.int_hs_osc_halt;
            end
            OSC_MODE_SELECT_ADDR: begin
                rd_word[EXT_CLK_INPUT_SEL_BIT] = q.ext_clk_input_sel; // RULE17
                rd_word[MAIN_OSC_PIN_ENABLE_BIT] = q.main_osc_pin_enable;
                rd_word[OSC_GAIN_HIGH_BIT] = q.osc_gain_high;
                rd_word[SUB_OSC_PIN_ENABLE_BIT] = q.sub_osc_pin_enable; // RULE18
            end
            CPU_STATE_ADDR: rd_word[3:0] = q.state;
            STANDBY_CMD_ADDR: rd_word = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    assign wr_ok = (q.aw_addr <= STANDBY_CMD_ADDR) && (q.aw_addr[1:0] == 2'b00);
    assign do_write = q.aw_got && q.w_got && !q.bvalid;
    assign wd = q.w_data[7:0];
    assign running = (q.state == CCSS_INT_RUN) || (q.state == CCSS_HS_RUN)
        || (q.state == CCSS_SUB_RUN);

    // bus handshake, register writes and cpu state sequencing
    always_comb begin
        next_q = q;
        // write channel capture, either order
        if (AWVALID && !q.aw_got) begin
            next_q.aw_got = 1'b1;
            next_q.aw_addr = AWADDR;
        end
        if (WVALID && !q.w_got) begin
            next_q.w_got = 1'b1;
            next_q.w_data = WDATA;
            next_q.w_lane0 = WSTRB[0];
        end
        if (do_write) begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (q.w_lane0 && q.state != CCSS_RESET && q.state != CCSS_POR_WAIT) begin
                unique case (q.aw_addr)
                    PROC_CLOCK_CTRL_ADDR: next_q.cpu_sub_sel = wd[CPU_SUB_SEL_BIT];
                    MAIN_CLOCK_MODE_ADDR: begin
                        // source select may change only once per reset
                        if (!q.src_locked && wd[HS_SOURCE_SEL_BIT] != q.hs_source_sel) begin
                            next_q.hs_source_sel = wd[HS_SOURCE_SEL_BIT]; // RULE5
                            next_q.src_locked = 1'b1; // RULE5
                        end
                        next_q.main_clk_sel = wd[MAIN_CLK_SEL_BIT];
                    end
                    MAIN_OSC_CTRL_ADDR: next_q.main_osc_halt = wd[MAIN_OSC_HALT_BIT];
                    INT_OSC_MODE_ADDR: next_q.int_hs_osc_halt = wd[INT_HS_OSC_HALT_BIT];
                    OSC_MODE_SELECT_ADDR: begin
                        next_q.ext_clk_input_sel = wd[EXT_CLK_INPUT_SEL_BIT];
                        next_q.main_osc_pin_enable = wd[MAIN_OSC_PIN_ENABLE_BIT];
                        next_q.sub_osc_pin_enable = wd[SUB_OSC_PIN_ENABLE_BIT];
                        if (!q.gain_locked && wd[OSC_GAIN_HIGH_BIT] != q.osc_gain_high) begin
                            next_q.osc_gain_high = wd[OSC_GAIN_HIGH_BIT]; // RULE5
                            next_q.gain_locked = 1'b1; // RULE5
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (q.bvalid && BREADY) next_q.bvalid = 1'b0;
        // read channel
        if (ARVALID && !q.rvalid) begin
            next_q.rvalid = 1'b1;
            next_q.rdata = rd_ok ? rd_word : 32'h0000_0000;
            next_q.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rvalid && RREADY) next_q.rvalid = 1'b0;
        // state sequencing
        unique case (q.state)
            CCSS_RESET: begin
                if (!POR_THRESHOLD_SEL) next_q.state = CCSS_INT_RUN; // RULE1
                else if (SUPPLY_ABOVE_THRESHOLD) next_q.state = CCSS_POR_WAIT; // RULE2
            end
            CCSS_POR_WAIT: begin
                // reset processing delay before cpu start
                if (!SUPPLY_ABOVE_THRESHOLD) begin
                    next_q.state = CCSS_RESET; // RULE2
                    next_q.por_cnt = '0;
                end else if (q.por_cnt == POR_CNT_W'(POR_PROC_CYCLES - 1)) begin
                    next_q.state = CCSS_INT_RUN; // RULE2
                end else begin
                    next_q.por_cnt = q.por_cnt + 1'b1;
                end
            end
            CCSS_INT_RUN, CCSS_HS_RUN, CCSS_SUB_RUN: begin
                // track which source drives the cpu
                if (cpu_on_sub_status) next_q.state = CCSS_SUB_RUN;
                else if (main_on_hs_status) next_q.state = CCSS_HS_RUN;
                else next_q.state = CCSS_INT_RUN;
                if (HALT_EXEC) begin
                    if (cpu_on_sub_status) next_q.state = CCSS_SUB_HALT; // RULE11
                    else if (main_on_hs_status) next_q.state = CCSS_HS_HALT; // RULE11
                    else next_q.state = CCSS_INT_HALT; // RULE11
                end else if (STOP_EXEC && !cpu_on_sub_status) begin
                    // stop is not offered from subsystem operation
                    next_q.state = main_on_hs_status ? CCSS_HS_STOP : CCSS_INT_STOP; // RULE12
                end
            end
            CCSS_INT_HALT: if (WAKE_EVENT) next_q.state = CCSS_INT_RUN;
            CCSS_HS_HALT: if (WAKE_EVENT) next_q.state = CCSS_HS_RUN;
            CCSS_SUB_HALT: if (WAKE_EVENT) next_q.state = CCSS_SUB_RUN;
            CCSS_INT_STOP: if (WAKE_EVENT) next_q.state = CCSS_INT_RUN;
            CCSS_HS_STOP: if (WAKE_EVENT) next_q.state = CCSS_HS_RUN;
            default: next_q.state = CCSS_RESET;
        endcase
        // software standby request through the command register
        if (do_write && q.w_lane0 && running && q.aw_addr == STANDBY_CMD_ADDR) begin
            if (wd[HALT_CMD_BIT]) begin
                next_q.state = cpu_on_sub_status ? CCSS_SUB_HALT
                    : (main_on_hs_status ? CCSS_HS_HALT : CCSS_INT_HALT); // RULE11
            end else if (wd[STOP_CMD_BIT] && !cpu_on_sub_status) begin
                next_q.state = main_on_hs_status ? CCSS_HS_STOP : CCSS_INT_STOP; // RULE12
            end
        end
        if (do_write && q.w_lane0 && !running && q.aw_addr == STANDBY_CMD_ADDR
            && wd[WAKE_CMD_BIT] && q.state != CCSS_RESET && q.state != CCSS_POR_WAIT) begin
            next_q.state = cpu_on_sub_status ? CCSS_SUB_RUN
                : (main_on_hs_status ? CCSS_HS_RUN : CCSS_INT_RUN);
        end
    end

    // state register; reset lands on the internal oscillator
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.state <= CCSS_RESET;
            q.main_osc_halt <= MAIN_OSC_HALT_RST;
            q.int_hs_osc_halt <= INT_HS_OSC_HALT_RST; // RULE1
        end else begin
            q <= next_q;
        end
    end

    // bus outputs
    assign AWREADY = !q.aw_got;
    assign WREADY = !q.w_got;
    assign BVALID = q.bvalid;
    assign BRESP = q.bresp;
    assign ARREADY = !q.rvalid;
    assign RVALID = q.rvalid;
    assign RDATA = q.rdata;
    assign RRESP = q.rresp;

    // clock routing and gating
    assign MAIN_CLK = main_clk_raw;
    assign PERIPH_CLK = q.hs_source_sel ? HS_SYS_CLK : INT_OSC_CLK; // RULE19
    assign CPU_CLK = running ? cpu_clk_raw : 1'b0;
    assign CPU_RESET_N = (q.state != CCSS_RESET) && (q.state != CCSS_POR_WAIT); // RULE2
    assign CPU_HALTED = (q.state == CCSS_INT_HALT) || (q.state == CCSS_HS_HALT)
        || (q.state == CCSS_SUB_HALT);
    assign CPU_STOPPED = (q.state == CCSS_INT_STOP) || (q.state == CCSS_HS_STOP);
    assign MAIN_OSC_RUN = q.main_osc_pin_enable && !q.main_osc_halt && !CPU_STOPPED;
    assign INT_OSC_RUN = !q.int_hs_osc_halt && !CPU_STOPPED;
    assign SUB_OSC_RUN = q.sub_osc_pin_enable;
    assign EXT_CLK_INPUT_SEL = q.ext_clk_input_sel;
    assign OSC_GAIN_HIGH = q.osc_gain_high;
endmodule // ccss_sequencer
`default_nettype wire

// >>> testbench/ccss_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ccss_seq_sva
    import ccss_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic POR_THRESHOLD_SEL,
    input wire logic SUPPLY_ABOVE_THRESHOLD,
    input wire logic HALT_EXEC,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic CPU_CLK,
    input wire logic CPU_RESET_N,
    input wire logic CPU_HALTED,
    input wire logic CPU_STOPPED,
    input wire logic MAIN_OSC_RUN,
    input wire logic SUB_OSC_RUN,
    input wire logic OSC_GAIN_HIGH
);
    logic gain_prev;
    logic gain_chg;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // track whether the gain flag has moved since reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gain_prev <= 1'h0;
            gain_chg <= 1'h0;
        end else begin
            gain_prev <= OSC_GAIN_HIGH;
            if (gain_prev != OSC_GAIN_HIGH) gain_chg <= 1'h1;
        end
    end
    AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read response dropped");
    AST_AR_BUSY: assert property (RVALID |-> !ARREADY)
        else $error("read taken while busy");
    AST_R_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    AST_POR_HOLD: assert property (
        POR_THRESHOLD_SEL && !SUPPLY_ABOVE_THRESHOLD && !CPU_RESET_N |=> !CPU_RESET_N)
        else $error("cpu left reset below threshold");
    AST_POR_DELAY: assert property (
        $rose(SUPPLY_ABOVE_THRESHOLD) && POR_THRESHOLD_SEL && !CPU_RESET_N
        |=> !CPU_RESET_N [*8]) else $error("reset processing too short");
    AST_RELEASE_INT: assert property ($rose(CPU_RESET_N) |->
        !MAIN_OSC_RUN && !SUB_OSC_RUN && !CPU_HALTED && !CPU_STOPPED)
        else $error("reset release not on internal osc");
    AST_GAIN_ONCE: assert property (gain_chg |-> OSC_GAIN_HIGH == gain_prev)
        else $error("gain changed twice");
    AST_HALT_ENTRY: assert property (
        HALT_EXEC && CPU_RESET_N && !CPU_HALTED && !CPU_STOPPED |=> CPU_HALTED)
        else $error("halt not entered");
    AST_HALT_STOP: assert property (!(CPU_HALTED && CPU_STOPPED))
        else $error("halt and stop together");
    AST_RESET_CLK: assert property (!CPU_RESET_N |-> !CPU_CLK)
        else $error("cpu clock in reset");
endmodule // ccss_seq_sva
bind ccss_sequencer ccss_seq_sva u_sva (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .POR_THRESHOLD_SEL(POR_THRESHOLD_SEL),
    .SUPPLY_ABOVE_THRESHOLD(SUPPLY_ABOVE_THRESHOLD), .HALT_EXEC(HALT_EXEC),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .CPU_CLK(CPU_CLK),
    .CPU_RESET_N(CPU_RESET_N), .CPU_HALTED(CPU_HALTED), .CPU_STOPPED(CPU_STOPPED),
    .MAIN_OSC_RUN(MAIN_OSC_RUN), .SUB_OSC_RUN(SUB_OSC_RUN), .OSC_GAIN_HIGH(OSC_GAIN_HIGH)
);
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("Error %s exp %0h got %0h", n, e, s); end end
module tb
    import ccss_pkg::*;
;
    logic REF_CLK = 1'h0, RST_N = 1'h0, POR_THRESHOLD_SEL = 1'h0, SUPPLY_ABOVE_THRESHOLD = 1'h1;
    logic INT_OSC_CLK = 1'h0, HS_SYS_CLK = 1'h0, SUB_CLK = 1'h0, INT_OSC_STABLE = 1'h1;
    logic HALT_EXEC = 1'h0, STOP_EXEC = 1'h0, WAKE_EVENT = 1'h0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [31:0] WDATA = 32'h0000_0000, RDATA, rd_d;
    logic [3:0] WSTRB = 4'h0;
    logic [1:0] BRESP, RRESP, rd_r;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CPU_CLK, MAIN_CLK, PERIPH_CLK, ext;
    logic CPU_RESET_N, CPU_HALTED, CPU_STOPPED, MAIN_OSC_RUN, INT_OSC_RUN, SUB_OSC_RUN;
    logic EXT_CLK_INPUT_SEL, OSC_GAIN_HIGH;
    int error_cnt = 0;
    int samples_checked = 0;
    // reference and source clocks
    always #5 REF_CLK = ~REF_CLK;
    always #20 INT_OSC_CLK = ~INT_OSC_CLK;
    always #30 HS_SYS_CLK = ~HS_SYS_CLK;
    always #50 SUB_CLK = ~SUB_CLK;
    ccss_sequencer dut (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .POR_THRESHOLD_SEL(POR_THRESHOLD_SEL),
        .SUPPLY_ABOVE_THRESHOLD(SUPPLY_ABOVE_THRESHOLD), .INT_OSC_CLK(INT_OSC_CLK),
        .HS_SYS_CLK(HS_SYS_CLK), .SUB_CLK(SUB_CLK), .INT_OSC_STABLE(INT_OSC_STABLE),
        .HALT_EXEC(HALT_EXEC), .STOP_EXEC(STOP_EXEC), .WAKE_EVENT(WAKE_EVENT),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .CPU_CLK(CPU_CLK),
        .MAIN_CLK(MAIN_CLK), .PERIPH_CLK(PERIPH_CLK), .CPU_RESET_N(CPU_RESET_N),
        .CPU_HALTED(CPU_HALTED), .CPU_STOPPED(CPU_STOPPED), .MAIN_OSC_RUN(MAIN_OSC_RUN),
        .INT_OSC_RUN(INT_OSC_RUN), .SUB_OSC_RUN(SUB_OSC_RUN),
        .EXT_CLK_INPUT_SEL(EXT_CLK_INPUT_SEL), .OSC_GAIN_HIGH(OSC_GAIN_HIGH)
    );
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one axi4-lite transfer, random ready delay
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        int dly;
        n = 0;
        dly = $urandom % 4;
        if (w) begin
            AWADDR <= a;
            WDATA <= d;
            WSTRB <= 4'h1;
            AWVALID <= 1'h1;
            WVALID <= 1'h1;
            BREADY <= (dly == 0);
        end else begin
            ARADDR <= a;
            ARVALID <= 1'h1;
            RREADY <= (dly == 0);
        end
        while (n < 100) begin
            @(posedge REF_CLK);
            n++;
            if (w ? (BVALID === 1'h1 && BREADY === 1'h1) : (RVALID === 1'h1 && RREADY === 1'h1))
                break;
            if (AWREADY === 1'h1) AWVALID <= 1'h0;
            if (WREADY === 1'h1) WVALID <= 1'h0;
            if (ARREADY === 1'h1) ARVALID <= 1'h0;
            if (w) BREADY <= (n >= dly); else RREADY <= (n >= dly);
        end
        rd_d = RDATA;
        rd_r = w ? BRESP : RRESP;
        BREADY <= 1'h0;
        RREADY <= 1'h0;
        @(posedge REF_CLK);
        if (n >= 100) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
        `CHK("bresp", RESP_OKAY, rd_r)
    endtask
    // poll a register until it matches, bounded
    task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
        int k;
        k = 0;
        do begin
            bus(1'h0, a, 32'h0000_0000);
            k++;
        end while (rd_d !== e && k < 200);
        `CHK(s, e, rd_d)
        `CHK(s, RESP_OKAY, rd_r)
        if (rd_d !== e) end_of_test();
    endtask
    task automatic pulse(input int k);
        case (k)
            0: HALT_EXEC <= 1'h1;
            1: STOP_EXEC <= 1'h1;
            default: WAKE_EVENT <= 1'h1;
        endcase
        @(posedge REF_CLK);
        HALT_EXEC <= 1'h0;
        STOP_EXEC <= 1'h0;
        WAKE_EVENT <= 1'h0;
        repeat (3) @(posedge REF_CLK);
    endtask
    function automatic logic [31:0] exp_sb(input ccss_state_t run, input logic stop);
        case (run)
            CCSS_INT_RUN: return 32'(stop ? CCSS_INT_STOP : CCSS_INT_HALT);
            CCSS_HS_RUN: return 32'(stop ? CCSS_HS_STOP : CCSS_HS_HALT);
            default: return 32'(stop ? CCSS_SUB_RUN : CCSS_SUB_HALT);
        endcase
    endfunction
    // halt, wake, stop, wake
    task automatic sby(input ccss_state_t run);
        if ($urandom % 2) pulse(0); else wr(STANDBY_CMD_ADDR, 32'h0000_0001);
        `CHK("halted", 1'h1, CPU_HALTED)
        rchk("halt state", CPU_STATE_ADDR, exp_sb(run, 1'h0));
        if ($urandom % 2) pulse(2); else wr(STANDBY_CMD_ADDR, 32'h0000_0004);
        rchk("woke", CPU_STATE_ADDR, 32'(run));
        if ($urandom % 2) pulse(1); else wr(STANDBY_CMD_ADDR, 32'h0000_0002);
        rchk("stop state", CPU_STATE_ADDR, exp_sb(run, 1'h1));
        `CHK("stopped", run != CCSS_SUB_RUN, CPU_STOPPED)
        pulse(2);
        $display("test standby %0d done", run);
    endtask
    task automatic rst(input logic por);
        RST_N <= 1'h0;
        POR_THRESHOLD_SEL <= por;
        SUPPLY_ABOVE_THRESHOLD <= !por;
        repeat (5) @(posedge REF_CLK);
        RST_N <= 1'h1;
        repeat (2) @(posedge REF_CLK);
    endtask
    // main sequence
    initial begin
        int n;
        void'($urandom(32'h16dd_7a32));
        rst(1'h0);
        `CHK("cpu reset", 1'h1, CPU_RESET_N)
        `CHK("main osc off", 1'h0, MAIN_OSC_RUN)
        rchk("state", CPU_STATE_ADDR, 32'(CCSS_INT_RUN));
        rchk("mclk mode", MAIN_CLOCK_MODE_ADDR, 32'h0000_0000);
        rchk("mosc halt", MAIN_OSC_CTRL_ADDR, 32'h0000_0080);
        rchk("int ready", INT_OSC_MODE_ADDR, 32'h0000_0080);
        INT_OSC_STABLE <= 1'h0;
        rchk("int unready", INT_OSC_MODE_ADDR, 32'h0000_0000);
        INT_OSC_STABLE <= 1'h1;
        repeat (3) begin
            bus(1'h0, 8'h1c + 8'(4 * ($urandom % 57)), 32'h0000_0000);
            `CHK("unmapped resp", RESP_SLVERR, rd_r)
            `CHK("unmapped data", 32'h0000_0000, rd_d)
        end
        $display("test reset done");
        // gain high suits the 16.7 MHz source; ext input random
        ext = 1'($urandom);
        wr(OSC_MODE_SELECT_ADDR, {24'h00_0000, ext, 7'h60});
        `CHK("ext sel", ext, EXT_CLK_INPUT_SEL)
        `CHK("gain", 1'h1, OSC_GAIN_HIGH)
        wr(OSC_MODE_SELECT_ADDR, {24'h00_0000, ext, 7'h40});
        rchk("gain once", OSC_MODE_SELECT_ADDR, {24'h00_0000, ext, 7'h60});
        wr(MAIN_OSC_CTRL_ADDR, 32'h0000_0000);
        `CHK("main osc run", 1'h1, MAIN_OSC_RUN)
        wr(MAIN_CLOCK_MODE_ADDR, 32'h0000_0004);
        rchk("periph hs", MAIN_CLOCK_MODE_ADDR, 32'h0000_0004);
        rchk("still int", CPU_STATE_ADDR, 32'(CCSS_INT_RUN));
        wr(MAIN_CLOCK_MODE_ADDR, 32'h0000_0005);
        rchk("main on hs", MAIN_CLOCK_MODE_ADDR, 32'h0000_0007);
        rchk("hs state", CPU_STATE_ADDR, 32'(CCSS_HS_RUN));
        wr(MAIN_CLOCK_MODE_ADDR, 32'h0000_0001);
        rchk("src once", MAIN_CLOCK_MODE_ADDR, 32'h0000_0007);
        sby(CCSS_HS_RUN);
        wr(OSC_MODE_SELECT_ADDR, {24'h00_0000, ext, 7'h70});
        `CHK("sub osc run", 1'h1, SUB_OSC_RUN)
        repeat (50) @(posedge REF_CLK);
        wr(PROC_CLOCK_CTRL_ADDR, 32'h0000_0010);
        rchk("on sub", PROC_CLOCK_CTRL_ADDR, 32'h0000_0030);
        rchk("sub state", CPU_STATE_ADDR, 32'(CCSS_SUB_RUN));
        sby(CCSS_SUB_RUN);
        wr(PROC_CLOCK_CTRL_ADDR, 32'h0000_0000);
        rchk("to hs", CPU_STATE_ADDR, 32'(CCSS_HS_RUN));
        rchk("ready", INT_OSC_MODE_ADDR, 32'h0000_0080);
        wr(MAIN_CLOCK_MODE_ADDR, 32'h0000_0004);
        rchk("to int", CPU_STATE_ADDR, 32'(CCSS_INT_RUN));
        wr(PROC_CLOCK_CTRL_ADDR, 32'h0000_0010);
        rchk("to sub", CPU_STATE_ADDR, 32'(CCSS_SUB_RUN));
        wr(MAIN_CLOCK_MODE_ADDR, 32'h0000_0004);
        wr(PROC_CLOCK_CTRL_ADDR, 32'h0000_0000);
        rchk("back int", CPU_STATE_ADDR, 32'(CCSS_INT_RUN));
        rchk("sub status", PROC_CLOCK_CTRL_ADDR, 32'h0000_0000);
        sby(CCSS_INT_RUN);
        // high threshold power-on clear, 11 us is 1100 cycles
        rst(1'h1);
        wr(OSC_MODE_SELECT_ADDR, 32'h0000_0020);
        repeat (20) @(posedge REF_CLK);
        `CHK("por hold", 1'h0, CPU_RESET_N)
        `CHK("por no write", 1'h0, OSC_GAIN_HIGH)
        SUPPLY_ABOVE_THRESHOLD <= 1'h1;
        n = 0;
        while (CPU_RESET_N !== 1'h1 && n < 3000) begin
            @(posedge REF_CLK);
            n++;
        end
        `CHK("por delay", 1'h1, n >= 1100 && n <= 1106)
        rchk("por state", CPU_STATE_ADDR, 32'(CCSS_INT_RUN));
        wr(OSC_MODE_SELECT_ADDR, 32'h0000_0020);
        `CHK("gain after reset", 1'h1, OSC_GAIN_HIGH)
        $display("test por done");
        end_of_test();
    end
endmodule // tb
`default_nettype wire
